//--- rtl/motor_drive_alarm_encoder.sv
// Alarm detection, latching and LED reporting for the multi-axis driver
`timescale 1ns/10ps
`default_nettype none
module motor_drive_alarm_encoder
  import alarm_pkg::*;
#(
  parameter int NUM_AXES   = 4,
  parameter int ON_CYCLES  = ON_CYC,
  parameter int OFF_CYCLES = OFF_CYC,
  parameter int GAP_CYCLES = GAP_CYC
) (
  input  wire logic                I_CLK,
  input  wire logic                I_SYS_RST,
  input  wire logic                I_ALM_RESET,
  input  wire logic                I_PWRUP_CHECK,
  input  wire logic                I_OTHER_AXIS_EN,
  input  wire logic [NUM_AXES-1:0] I_AXIS_ALM,
  input  wire logic                I_PARAM_CORRUPT,
  input  wire logic                I_SENSOR_FAULT,
  input  wire logic                I_SHAFT_ROTATING,
  input  wire logic                I_SENSOR_DATA_BAD,
  input  wire logic                I_MOTOR_UNSUPPORTED,
  input  wire logic                I_ABS_MOVE_START,
  input  wire logic                I_COORD_SET,
  input  wire logic                I_ABS_NOCOORD_PERMIT,
  input  wire logic                I_REGEN_ALM_EN,
  input  wire logic                I_REGEN_OVERHEAT,
  input  wire logic                I_REGEN_PRESENT,
  output logic                     O_ALARM,
  output logic [7:0]               O_ALM_CODE,
  output logic                     O_PWR_CYCLE_ONLY,
  output logic                     O_LED
);

  logic [NUM_CAUSES-1:0] det;
  logic [7:0]            new_code;
  logic                  new_valid;
  logic [7:0]            code_r;
  logic                  take;

  blink_if bl ();

  // ----------------------------------------
  // Cause detection
  // ----------------------------------------
  always_comb begin
    // RULE_02 controller data corrupt
    det[0] = I_PARAM_CORRUPT;
    // RULE_03 sensor fault power-up
    det[1] = I_PWRUP_CHECK && I_SENSOR_FAULT;
    // RULE_04 rotation at power-up
    det[2] = I_PWRUP_CHECK && I_SHAFT_ROTATING;
    // RULE_05 sensor data corrupt
    det[3] = I_SENSOR_DATA_BAD;
    // RULE_06 unsupported motor
    det[4] = I_MOTOR_UNSUPPORTED;
    // RULE_01 other axis alarm
    det[5] = I_OTHER_AXIS_EN && (|I_AXIS_ALM);
    // RULE_07 move without coordinates
    det[6] = I_ABS_MOVE_START && !I_COORD_SET && !I_ABS_NOCOORD_PERMIT;
    // RULE_08 regen resistor fault
    det[7] = I_REGEN_ALM_EN && (I_REGEN_OVERHEAT || !I_REGEN_PRESENT);
  end

  // Lowest index wins; power-cycle causes sit at the low indices
  always_comb begin
    new_code  = CODE_NONE;
    new_valid = 1'b0;
    for (int i = NUM_CAUSES - 1; i >= 0; i--) begin
      if (det[i]) begin
        new_code  = code_of(i);
        new_valid = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Alarm latch
  // ----------------------------------------
  // A power-cycle alarm may displace a resettable one, never the reverse.
  // Detection in the reset cycle wins over the clear.
  assign take = new_valid && (code_r == CODE_NONE
             || (resettable(code_r) && (I_ALM_RESET || !resettable(new_code))));

  // RULE_10 latch until cleared
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      code_r <= CODE_NONE;
    end else if (take) begin
      code_r <= new_code;
    end else if (I_ALM_RESET && resettable(code_r)) begin
      code_r <= CODE_NONE;
    end
  end

  assign O_ALM_CODE       = code_r;
  assign O_ALARM          = (code_r != CODE_NONE);
  assign O_PWR_CYCLE_ONLY = O_ALARM && !resettable(code_r);

  // ----------------------------------------
  // LED reporting
  // ----------------------------------------
  // RULE_10 blink count from code
  assign bl.active = O_ALARM;
  assign bl.blinks = blinks_of(code_r);
  assign O_LED     = bl.led;

  led_blinker #(
    .ON_CYCLES  (ON_CYCLES),
    .OFF_CYCLES (OFF_CYCLES),
    .GAP_CYCLES (GAP_CYCLES)
  ) u_blink (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .bl    (bl.seq)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  // RULE_01 other-axis code
  property p_other_axis;
    det == 8'h20 && code_r == CODE_NONE
      |=> code_r == CODE_OTHER_AXIS && bl.blinks == BLINKS_2;
  endproperty
  a_other_axis: assert property (p_other_axis) else $error("other-axis code wrong"); // RULE_01

  // RULE_01 setting off gates it
  property p_other_gate;
    !I_OTHER_AXIS_EN && code_r == CODE_NONE && det[4:0] == 5'h00 && det[7:6] == 2'h0
      |=> code_r == CODE_NONE;
  endproperty
  a_other_gate: assert property (p_other_gate) else $error("disabled other-axis raised"); // RULE_01

  // RULE_02 controller data code
  property p_param;
    I_PARAM_CORRUPT && !O_PWR_CYCLE_ONLY
      |=> code_r == CODE_PARAM_CORRUPT && bl.blinks == BLINKS_9;
  endproperty
  a_param: assert property (p_param) else $error("parameter corrupt code wrong"); // RULE_02

  // RULE_03 power-up sensor code
  property p_sensor_pwrup;
    det == 8'h02 && !O_PWR_CYCLE_ONLY
      |=> code_r == CODE_SENSOR_PWRUP && bl.blinks == BLINKS_8;
  endproperty
  a_sensor_pwrup: assert property (p_sensor_pwrup) else $error("power-up sensor code wrong"); // RULE_03

  // RULE_04 rotation code
  property p_rotate;
    det == 8'h04 && !O_PWR_CYCLE_ONLY
      |=> code_r == CODE_ROTATE_PWRUP && bl.blinks == BLINKS_8 && O_PWR_CYCLE_ONLY;
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotation code wrong"); // RULE_04

  // RULE_05 sensor data code
  property p_sensor_data;
    det == 8'h08 && !O_PWR_CYCLE_ONLY
      |=> code_r == CODE_SENSOR_DATA && bl.blinks == BLINKS_8;
  endproperty
  a_sensor_data: assert property (p_sensor_data) else $error("sensor data code wrong"); // RULE_05

  // RULE_06 motor type code
  property p_motor;
    det == 8'h10 && !O_PWR_CYCLE_ONLY
      |=> code_r == CODE_MOTOR_TYPE && bl.blinks == BLINKS_8 ##1 code_r == CODE_MOTOR_TYPE;
  endproperty
  a_motor: assert property (p_motor) else $error("motor type code wrong"); // RULE_06

  // RULE_07 move without coordinates
  property p_no_coord_raise;
    I_ABS_MOVE_START && !I_COORD_SET && !I_ABS_NOCOORD_PERMIT && code_r == CODE_NONE
      && det[5:0] == 6'h00 |=> code_r == CODE_NO_COORD && bl.blinks == BLINKS_7;
  endproperty
  a_no_coord_raise: assert property (p_no_coord_raise) else $error("no-coord code wrong"); // RULE_07

  // RULE_07 permitted or set move
  property p_no_coord;
    I_ABS_MOVE_START && (I_ABS_NOCOORD_PERMIT || I_COORD_SET) && code_r == CODE_NONE
      && det[5:0] == 6'h00 && !det[7] |=> code_r == CODE_NONE;
  endproperty
  a_no_coord: assert property (p_no_coord) else $error("permitted move raised alarm"); // RULE_07

  // RULE_08 regen resistor code
  property p_regen;
    det == 8'h80 && code_r == CODE_NONE
      |=> code_r == CODE_REGEN_HOT && bl.blinks == BLINKS_2;
  endproperty
  a_regen: assert property (p_regen) else $error("regen code wrong"); // RULE_08

  // RULE_08 disabled regen alarm
  property p_regen_gate;
    !I_REGEN_ALM_EN && code_r == CODE_NONE && det[6:0] == 7'h00 |=> code_r == CODE_NONE;
  endproperty
  a_regen_gate: assert property (p_regen_gate) else $error("disabled regen alarm raised"); // RULE_08

  // ----------------------------------------
  // Latch and LED checks
  // ----------------------------------------
  // RULE_10 power-cycle code holds
  property p_hold;
    O_PWR_CYCLE_ONLY |=> $stable(code_r)[*3];
  endproperty
  a_hold: assert property (p_hold) else $error("power-cycle alarm changed"); // RULE_10

  // RULE_10 reset clears resettable
  property p_reset_clear;
    I_ALM_RESET && det == 8'h00 && (code_r == CODE_OTHER_AXIS || code_r == CODE_NO_COORD
      || code_r == CODE_REGEN_HOT) |=> code_r == CODE_NONE;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("alarm reset did not clear"); // RULE_10

  // RULE_10 resettable code kept
  property p_refuse;
    O_ALARM && !O_PWR_CYCLE_ONLY && det[4:0] == 5'h00 && !I_ALM_RESET |=> $stable(code_r);
  endproperty
  a_refuse: assert property (p_refuse) else $error("latched code replaced"); // RULE_10

  // RULE_10 power-cycle cause displaces
  property p_displace;
    O_ALARM && !O_PWR_CYCLE_ONLY && det[4:0] != 5'h00 |=> O_PWR_CYCLE_ONLY;
  endproperty
  a_displace: assert property (p_displace) else $error("power-cycle cause not taken"); // RULE_10

  // RULE_10 burst starts
  property p_led_start;
    $rose(O_ALARM) |=> O_LED;
  endproperty
  a_led_start: assert property (p_led_start) else $error("led did not start"); // RULE_10

  // RULE_10 dark without alarm
  property p_led_off;
    !O_ALARM |=> !O_LED;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led lit without alarm"); // RULE_10

endmodule // motor_drive_alarm_encoder
`default_nettype wire

//--- common/alarm_pkg.sv
// Alarm codes, blink counts, timing and state types for the alarm encoder
// How it works
// RULE_01: With the other-axis alarm setting on and any axis in alarm, code 35h with 2 blinks is raised, cleared by any reset.
// RULE_02: Corrupted controller parameter data raises code 41h with 9 blinks, cleared only by a power cycle.
// RULE_03: A position sensor fault during power-up raises code 42h with 8 blinks, cleared only by a power cycle.
// RULE_04: A shaft found rotating at power-up raises code 43h with 8 blinks, cleared only by a power cycle.
// RULE_05: Corrupted data inside the position sensor raises code 44h with 8 blinks, cleared only by a power cycle.
// RULE_06: An unsupported motor type raises code 45h with 8 blinks, cleared only by a power cycle.
// RULE_07: An absolute move started without coordinates raises code 4Ah with 7 blinks unless permitted, cleared by any reset.
// RULE_08: With the regen overheat alarm on, overheat or a missing resistor raises code 51h with 2 blinks, cleared by any reset.
// RULE_09: After an other-axis alarm is resolved the host resets each affected axis separately.
// RULE_10: The active code is latched and its blink pattern repeats until its own clearing condition occurs;
// the code also lets a power-cycle cause displace a latched resettable code before that.
package alarm_pkg;

  // ----------------------------------------
  // Alarm codes
  // ----------------------------------------
  localparam logic [7:0] CODE_NONE          = 8'h00;
  localparam logic [7:0] CODE_OTHER_AXIS    = 8'h35;
  localparam logic [7:0] CODE_PARAM_CORRUPT = 8'h41;
  localparam logic [7:0] CODE_SENSOR_PWRUP  = 8'h42;
  localparam logic [7:0] CODE_ROTATE_PWRUP  = 8'h43;
  localparam logic [7:0] CODE_SENSOR_DATA   = 8'h44;
  localparam logic [7:0] CODE_MOTOR_TYPE    = 8'h45;
  localparam logic [7:0] CODE_NO_COORD      = 8'h4A;
  localparam logic [7:0] CODE_REGEN_HOT     = 8'h51;

  localparam int         NUM_CAUSES = 8;
  localparam logic [3:0] BLINKS_2   = 4'h2;
  localparam logic [3:0] BLINKS_7   = 4'h7;
  localparam logic [3:0] BLINKS_8   = 4'h8;
  localparam logic [3:0] BLINKS_9   = 4'h9;

  // ----------------------------------------
  // Blink timing
  // ----------------------------------------
  localparam longint CLK_HZ       = 100_000_000;
  localparam longint BLINK_ON_MS  = 200;
  localparam longint BLINK_OFF_MS = 200;
  localparam longint BLINK_GAP_MS = 1000;
  localparam int     ON_CYC       = int'(BLINK_ON_MS * CLK_HZ / 1000);
  localparam int     OFF_CYC      = int'(BLINK_OFF_MS * CLK_HZ / 1000);
  localparam int     GAP_CYC      = int'(BLINK_GAP_MS * CLK_HZ / 1000);

  typedef enum logic [3:0] {
    BL_IDLE = 4'h1,
    BL_ON   = 4'h2,
    BL_OFF  = 4'h4,
    BL_GAP  = 4'h8
  } blink_state_e;

  // Cause index to code; lower index wins, power-cycle causes first
  function automatic logic [7:0] code_of(input int idx);
    case (idx)
      0:       code_of = CODE_PARAM_CORRUPT;
      1:       code_of = CODE_SENSOR_PWRUP;
      2:       code_of = CODE_ROTATE_PWRUP;
      3:       code_of = CODE_SENSOR_DATA;
      4:       code_of = CODE_MOTOR_TYPE;
      5:       code_of = CODE_OTHER_AXIS;
      6:       code_of = CODE_NO_COORD;
      default: code_of = CODE_REGEN_HOT;
    endcase
  endfunction

  function automatic logic [3:0] blinks_of(input logic [7:0] code);
    case (code)
      CODE_PARAM_CORRUPT:                  blinks_of = BLINKS_9;
      CODE_NO_COORD:                       blinks_of = BLINKS_7;
      CODE_OTHER_AXIS, CODE_REGEN_HOT:     blinks_of = BLINKS_2;
      CODE_NONE:                           blinks_of = 4'h0;
      default:                             blinks_of = BLINKS_8;
    endcase
  endfunction

  function automatic logic resettable(input logic [7:0] code);
    resettable = (code == CODE_OTHER_AXIS) || (code == CODE_NO_COORD)
              || (code == CODE_REGEN_HOT);
  endfunction

endpackage

//--- common/blink_if.sv
// Carrier between the alarm latch and the LED blink sequencer
`timescale 1ns/10ps
`default_nettype none
interface blink_if;
  logic       active;
  logic [3:0] blinks;
  logic       led;
  modport src (output active, output blinks, input led);
  modport seq (input active, input blinks, output led);
endinterface
`default_nettype wire

//--- rtl/led_blinker.sv
// LED blink sequencer: N pulses then a gap, repeated while an alarm stands
`timescale 1ns/10ps
`default_nettype none
module led_blinker
  import alarm_pkg::*;
#(
  parameter int ON_CYCLES  = ON_CYC,
  parameter int OFF_CYCLES = OFF_CYC,
  parameter int GAP_CYCLES = GAP_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  blink_if.seq      bl
);

  blink_state_e state_r;
  logic [31:0]  tmr_r;
  logic [3:0]   left_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Blink pattern repeats
  always_ff @(posedge i_clk) begin
    if (i_rst || !bl.active) begin
      state_r <= BL_IDLE;
      tmr_r   <= 32'h0;
      left_r  <= 4'h0;
    end else begin
      case (state_r)
        BL_IDLE: begin
          state_r <= BL_ON;
          tmr_r   <= 32'(ON_CYCLES - 1);
          left_r  <= bl.blinks;
        end
        BL_ON: begin
          if (tmr_r == 32'h0) begin
            state_r <= BL_OFF;
            tmr_r   <= 32'(OFF_CYCLES - 1);
            left_r  <= left_r - 4'h1;
          end else begin
            tmr_r <= tmr_r - 32'h1;
          end
        end
        BL_OFF: begin
          if (tmr_r != 32'h0) begin
            tmr_r <= tmr_r - 32'h1;
          end else if (left_r == 4'h0) begin
            state_r <= BL_GAP;
            tmr_r   <= 32'(GAP_CYCLES - 1);
          end else begin
            state_r <= BL_ON;
            tmr_r   <= 32'(ON_CYCLES - 1);
          end
        end
        BL_GAP: begin
          // Return to BL_IDLE, which reloads the count, so a code change shows from the next burst
          if (tmr_r == 32'h0) begin
            state_r <= BL_IDLE;
          end else begin
            tmr_r <= tmr_r - 32'h1;
          end
        end
        default: state_r <= BL_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bl.led <= 1'b0;
    end else begin
      bl.led <= bl.active && (state_r == BL_IDLE || (state_r == BL_ON && tmr_r != 32'h0));
    end
  end

endmodule // led_blinker
`default_nettype wire

//--- tb/plant_model.sv
// Far-side model: motor, position sensor, regen resistor and axis alarms
`timescale 1ns/10ps
`default_nettype none
module plant_model (
  input  wire logic       i_clk,
  input  wire logic [8:0] i_fault,
  output logic      [3:0] o_axis_alm,
  output logic            o_param,
  output logic            o_sfault,
  output logic            o_rot,
  output logic            o_sdata,
  output logic            o_motor,
  output logic            o_abs_start,
  output logic            o_hot,
  output logic            o_present
);
  logic abs_r;

  always_ff @(posedge i_clk) begin
    o_param     <= i_fault[0];
    o_sfault    <= i_fault[1];
    o_rot       <= i_fault[2];
    o_sdata     <= i_fault[3];
    o_motor     <= i_fault[4];
    o_axis_alm  <= {1'b0, i_fault[5], 2'b00};
    // One start pulse per request, as the host issues a move once
    o_abs_start <= i_fault[6] & ~abs_r;
    abs_r       <= i_fault[6];
    o_hot       <= i_fault[7];
    o_present   <= ~i_fault[8];
  end
endmodule // plant_model
`default_nettype wire

//--- tb/motor_drive_alarm_encoder_bench.sv
// Self-checking bench for the alarm encoder
`timescale 1ns/10ps
`default_nettype none
module motor_drive_alarm_encoder_bench;
  logic       clk, rst, alm_rst, pwrup, oth_en, coord, permit, rg_en;
  logic [8:0] fault;
  logic [3:0] axis;
  logic       param, sfault, rot, sdata, motor, abs_st, hot, present;
  logic       alarm, pwr_only, led;
  logic [7:0] code;
  int         err_count, checks;
  logic [7:0] exp_code [9] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h35, 8'h4A, 8'h51, 8'h51};
  logic [3:0] exp_blk [9]  = '{4'h9, 4'h8, 4'h8, 4'h8, 4'h8, 4'h2, 4'h7, 4'h2, 4'h2};
  int         gate_bit [6] = '{1, 2, 5, 6, 7, 8};

  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  motor_drive_alarm_encoder #(.NUM_AXES(4), .ON_CYCLES(3), .OFF_CYCLES(3), .GAP_CYCLES(6)) dut_u (
    .I_CLK(clk), .I_SYS_RST(rst), .I_ALM_RESET(alm_rst), .I_PWRUP_CHECK(pwrup),
    .I_OTHER_AXIS_EN(oth_en), .I_AXIS_ALM(axis), .I_PARAM_CORRUPT(param),
    .I_SENSOR_FAULT(sfault), .I_SHAFT_ROTATING(rot), .I_SENSOR_DATA_BAD(sdata),
    .I_MOTOR_UNSUPPORTED(motor), .I_ABS_MOVE_START(abs_st), .I_COORD_SET(coord),
    .I_ABS_NOCOORD_PERMIT(permit), .I_REGEN_ALM_EN(rg_en), .I_REGEN_OVERHEAT(hot),
    .I_REGEN_PRESENT(present), .O_ALARM(alarm), .O_ALM_CODE(code),
    .O_PWR_CYCLE_ONLY(pwr_only), .O_LED(led));

  plant_model plant_u (
    .i_clk(clk), .i_fault(fault), .o_axis_alm(axis), .o_param(param), .o_sfault(sfault),
    .o_rot(rot), .o_sdata(sdata), .o_motor(motor), .o_abs_start(abs_st), .o_hot(hot),
    .o_present(present));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_s(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic power_cycle;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Drop the cause first so set-wins does not re-latch it
  task automatic drop_and_reset;
    @(posedge clk) fault <= 9'h000;
    repeat (3) @(posedge clk);
    alm_rst <= 1'b1;
    @(posedge clk) alm_rst <= 1'b0;
    wait_s(2);
  endtask

  // Counts blinks of one full burst, framed by two long low runs
  task automatic blinks(output int n);
    int lc, b;
    lc = 0;
    b = 0;
    n = 0;
    for (int i = 0; i < 400 && b < 2; i++) begin
      wait_s(1);
      if (led === 1'b1) begin
        if (lc > 6) b++;
        if (lc > 0 && b == 1) n++;
        lc = 0;
      end else lc++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_codes;
    int n;
    for (int k = 0; k < 9; k++) begin
      power_cycle();
      @(posedge clk) fault <= 9'h001 << k;
      wait_s(4);
      chk("code", code, exp_code[k]);
      chk("pwr_only", {7'h00, pwr_only}, {7'h00, k < 5});
      blinks(n);
      chk("blinks", 8'(n), {4'h0, exp_blk[k]});
      drop_and_reset();
      chk("code after reset", code, (k < 5) ? exp_code[k] : 8'h00);
    end
    $display("test codes done");
  endtask

  task automatic t_prio;
    power_cycle();
    @(posedge clk) fault <= 9'h040;
    wait_s(4);
    @(posedge clk) fault <= 9'h020;
    wait_s(4);
    chk("held code", code, 8'h4A);
    @(posedge clk) fault <= 9'h021;
    wait_s(4);
    chk("replaced code", code, 8'h41);
    drop_and_reset();
    chk("kept code", code, 8'h41);
    power_cycle();
    wait_s(3);
    chk("cleared", {code[7:2], alarm, led}, 8'h00);
    @(posedge clk) fault <= 9'h01C;
    wait_s(4);
    chk("first of three", code, 8'h43);
    @(posedge clk) fault <= 9'h000;
    $display("test priority done");
  endtask

  task automatic t_gates;
    @(posedge clk) begin
      pwrup  <= 1'b0;
      oth_en <= 1'b0;
      rg_en  <= 1'b0;
      permit <= 1'b1;
    end
    for (int j = 0; j < 6; j++) begin
      power_cycle();
      @(posedge clk) fault <= 9'h001 << gate_bit[j];
      wait_s(4);
      chk("gated code", code, 8'h00);
      @(posedge clk) fault <= 9'h000;
    end
    // Coordinates set, permission off: the move is legal
    @(posedge clk) begin
      permit <= 1'b0;
      coord  <= 1'b1;
    end
    power_cycle();
    @(posedge clk) fault <= 9'h040;
    wait_s(4);
    chk("coord set code", code, 8'h00);
    chk("coord set alarm", {7'h00, alarm}, 8'h00);
    @(posedge clk) fault <= 9'h000;
    $display("test gates done");
  endtask

  initial begin
    rst       = 1'b1;
    alm_rst   = 1'b0;
    pwrup     = 1'b1;
    oth_en    = 1'b1;
    coord     = 1'b0;
    permit    = 1'b0;
    rg_en     = 1'b1;
    fault     = 9'h000;
    err_count = 0;
    checks    = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_codes();
    t_prio();
    t_gates();
    tally_and_finish();
  end

  // Whole run needs about 1000 cycles; this allows twenty times that
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
endmodule // motor_drive_alarm_encoder_bench
`default_nettype wire
